// ===== pph_map.vh
// port map, field codes and timing constants for the parallel host port
`ifndef PPH_MAP_VH
`define PPH_MAP_VH
`define PPH_PORT_COUNT 32
`define PPH_OUT_COUNT 20
`define PPH_IN_COUNT 8
`define PPH_VOLT_PORTS 16
`define PPH_VIN_PORTS 6
`define PPH_OUT_FIRST 8'h00
`define PPH_DAC_ONE 8'h10
`define PPH_DAC_TWO 8'h11
`define PPH_DAC_THREE 8'h12
`define PPH_AUX_PORT 8'h13
`define PPH_IN_FIRST 8'h18
`define PPH_LATCH_RESET 8'h00
`define PPH_SEL_DISABLE 2'h0
`define PPH_SEL_ONE 2'h1
`define PPH_SEL_TWO 2'h2
`define PPH_SEL_THREE 2'h3
`define PPH_CLK_HZ 100000000
`define PPH_SQW_HZ 3000000
`endif

// ===== pph_host_port.v
// parallel host port with output latches, input ports and a square-wave pin clock
`timescale 1ns/1ns
`include "pph_map.vh"

// Overview of operation
// - split mode: one strobe writes address-selected port
// - split mode: input data follows address, unstrobed
// - muxed mode: address strobe latches the address
// - muxed mode: data strobe writes addressed port
// - muxed mode: input strobe drives shared lines
// - sixteen voltage latches, six voltage input ports
// - 32 addresses: 20 writable, 8 readable
// - latch bits drive switches until rewritten
// - three 8-bit converter settings, one per supply
// - any pin can be logic high or low
// - back-to-back transfers every cycle accepted
// - primary 0 is zero volts, 1 positive
// - secondary 00 disable, 01-11 select supply
// - clock option is a 3.125MHz square wave
module pph_host_port #(
	parameter NPORT = `PPH_PORT_COUNT,
	parameter NOUT = `PPH_OUT_COUNT,
	parameter NIN = `PPH_IN_COUNT
) (
	input wire clock,
	input wire resetn,
	input wire mux_mode,
	input wire [7:0] port_addr,
	input wire [7:0] write_data,
	input wire xfer_strobe,
	output wire [7:0] read_data,
	input wire [7:0] mux_bus_in,
	output wire [7:0] mux_bus_out,
	output wire mux_bus_oe,
	input wire addr_strobe,
	input wire data_strobe,
	input wire input_strobe,
	input wire [8*NIN-1:0] in_ports,
	output wire [8*NOUT-1:0] out_latches,
	output wire [7:0] dac_supply_one,
	output wire [7:0] dac_supply_two,
	output wire [7:0] dac_supply_three,
	output wire [7:0] aux_control,
	output reg square_clock
);

	// half period of the pin clock, in system clocks
	localparam [31:0] HALF = `PPH_CLK_HZ / (2 * `PPH_SQW_HZ);
	localparam [4:0] HALF_CNT = (HALF < 1) ? 5'h01 : HALF[4:0];
	localparam [4:0] HALF_LAST = HALF_CNT - 5'h01;

	// port map limits at the width of the address
	localparam [31:0] OUT_LIMIT_W = NOUT;
	localparam [31:0] PORT_LIMIT_W = NPORT;
	localparam [7:0] OUT_LIMIT = OUT_LIMIT_W[7:0];
	localparam [7:0] PORT_LIMIT = PORT_LIMIT_W[7:0];
	localparam [7:0] IN_FIRST = `PPH_IN_FIRST;

	// lowest bit of each converter and auxiliary latch
	localparam integer DAC_ONE_LSB = 8 * `PPH_DAC_ONE;
	localparam integer DAC_TWO_LSB = 8 * `PPH_DAC_TWO;
	localparam integer DAC_THREE_LSB = 8 * `PPH_DAC_THREE;
	localparam integer AUX_LSB = 8 * `PPH_AUX_PORT;

	// strobes qualified against each other
	reg only_addr;
	reg only_data;
	reg only_input;
	wire split_write;
	wire muxed_write;
	wire muxed_addr_load;
	wire muxed_read;

	// address and data of the current transfer
	reg [7:0] mux_addr;
	reg [7:0] next_mux_addr;
	wire [7:0] eff_addr;
	wire [7:0] eff_data;
	wire addr_writable;
	wire wr_en;

	// read side
	reg [7:0] in_sel;
	wire addr_above_first;
	wire addr_below_limit;
	wire addr_readable;
	integer k;

	// pin clock divider
	reg [4:0] sqw_cnt;
	reg [4:0] next_sqw_cnt;
	reg next_square_clock;

	// exactly one muxed strobe may act at a time
	always @* begin
		only_addr = 1'b0;
		only_data = 1'b0;
		only_input = 1'b0;
		case ({addr_strobe, data_strobe, input_strobe})
			3'h4: begin
				only_addr = 1'b1;
			end
			3'h2: begin
				only_data = 1'b1;
			end
			3'h1: begin
				only_input = 1'b1;
			end
			default: begin
				// idle or overlapping strobes: nothing acts
				only_addr = 1'b0;
			end
		endcase
	end

	// each high cycle of a write strobe is one transfer
	assign split_write = ~mux_mode & xfer_strobe;
	assign muxed_write = mux_mode & only_data;
	assign muxed_addr_load = mux_mode & only_addr;
	assign muxed_read = mux_mode & only_input;

	// a lone address strobe reloads the muxed address
	always @* begin
		next_mux_addr = mux_addr;
		if (muxed_addr_load) begin
			next_mux_addr = mux_bus_in;
		end
	end

	always @(posedge clock) begin
		if (!resetn) begin
			mux_addr <= 8'h00;
		end else begin
			mux_addr <= next_mux_addr;
		end
	end

	// split mode takes address and data straight from the pins
	assign eff_addr = mux_mode ? mux_addr : port_addr;
	assign eff_data = mux_mode ? mux_bus_in : write_data;
	// the unmapped gap 14-17 is neither written nor read
	assign addr_writable = (eff_addr < OUT_LIMIT);
	assign wr_en = (split_write | muxed_write) & addr_writable;

	// one latch per write port, 20 of them at 00-13
	genvar g;
	generate
		for (g = 0; g < NOUT; g = g + 1) begin : g_out
			wire hit;
			reg [7:0] value;
			reg [7:0] next_value;

			assign hit = wr_en & (eff_addr == g);

			always @* begin
				next_value = value;
				if (hit) begin
					next_value = eff_data;
				end
			end

			always @(posedge clock) begin
				if (!resetn) begin
					// reset keeps every supply off
					value <= `PPH_LATCH_RESET;
				end else begin
					// held until the same port is written again
					value <= next_value;
				end
			end

			assign out_latches[8*g+7:8*g] = value;
		end
	endgenerate

	// converter settings and the auxiliary port
	assign dac_supply_one = out_latches[DAC_ONE_LSB +: 8];
	assign dac_supply_two = out_latches[DAC_TWO_LSB +: 8];
	assign dac_supply_three = out_latches[DAC_THREE_LSB +: 8];
	assign aux_control = out_latches[AUX_LSB +: 8];

	// 8 read ports at 18-1F; unmapped reads give zero
	assign addr_above_first = (eff_addr >= IN_FIRST);
	assign addr_below_limit = (eff_addr < PORT_LIMIT);
	assign addr_readable = addr_above_first & addr_below_limit;

	always @* begin
		in_sel = 8'h00;
		for (k = 0; k < NIN; k = k + 1) begin
			if (addr_readable && (eff_addr == IN_FIRST + k[7:0])) begin
				in_sel = in_ports[8*k +: 8];
			end
		end
	end

	// the shared lines are driven only during a lone input strobe
	assign read_data = in_sel;
	assign mux_bus_out = in_sel;
	assign mux_bus_oe = muxed_read;

	// free-running square wave for the clock pin option
	// toggles once every HALF_CNT cycles
	always @* begin
		next_sqw_cnt = sqw_cnt + 5'h01;
		next_square_clock = square_clock;
		if (sqw_cnt == HALF_LAST) begin
			next_sqw_cnt = 5'h00;
			next_square_clock = ~square_clock;
		end
	end

	always @(posedge clock) begin
		if (!resetn) begin
			sqw_cnt <= 5'h00;
			square_clock <= 1'b0;
		end else begin
			sqw_cnt <= next_sqw_cnt;
			square_clock <= next_square_clock;
		end
	end

endmodule // pph_host_port

// ===== pph_pin_select.v
// decode of a two-bit secondary field and primary bit into a pin source
`timescale 1ns/1ns
`include "pph_map.vh"

module pph_pin_select (
	input wire primary,
	input wire [1:0] secondary,
	output wire zero_volt,
	output wire pullup_disable,
	output wire use_supply_one,
	output wire use_supply_two,
	output wire use_supply_three
);

	assign zero_volt = ~primary;
	assign pullup_disable = primary & (secondary == `PPH_SEL_DISABLE);
	assign use_supply_one = primary & (secondary == `PPH_SEL_ONE);
	assign use_supply_two = primary & (secondary == `PPH_SEL_TWO);
	assign use_supply_three = primary & (secondary == `PPH_SEL_THREE);

endmodule // pph_pin_select

// ===== pph_chk_checker.sv
// assertions on the ports of the parallel host port
`timescale 1ns/1ns
module pph_chk #(parameter NOUT = 20, NIN = 8) (input wire clock, resetn,
	input wire mux_mode, xfer_strobe, mux_bus_oe, addr_strobe, data_strobe,
	input wire input_strobe, input wire [7:0] port_addr, write_data,
	input wire [7:0] read_data, dac_supply_one, input wire [8*NIN-1:0] in_ports,
	input wire [8*NOUT-1:0] out_latches);
	default clocking @(posedge clock); endclocking
	default disable iff (!resetn);
	AST_SPL: assert property (!mux_mode && xfer_strobe && port_addr == 8'h10
		|=> dac_supply_one == $past(write_data)) else $error("split write");
	AST_RD: assert property (!mux_mode && port_addr == 8'h1A
		|-> read_data == in_ports[23:16]) else $error("split read");
	AST_OE: assert property (mux_mode && input_strobe && !addr_strobe
		&& !data_strobe |-> mux_bus_oe) else $error("no drive");
	AST_NOOE: assert property (!input_strobe |-> !mux_bus_oe)
		else $error("stray drive");
	AST_OVL: assert property (input_strobe && data_strobe
		|-> !mux_bus_oe) else $error("overlap drive");
	AST_HOLD: assert property (!xfer_strobe && !data_strobe
		|=> $stable(out_latches)) else $error("latch moved");
	AST_REF: assert property (!mux_mode && xfer_strobe
		&& port_addr >= 8'h14 |=> $stable(out_latches))
		else $error("bad port written");
	AST_DAC: assert property (dac_supply_one == out_latches[135:128])
		else $error("converter");
	cover property (mux_bus_oe);
	cover property (addr_strobe ##1 data_strobe);
	cover property (xfer_strobe ##1 xfer_strobe);
endmodule // pph_chk
bind pph_host_port pph_chk #(.NOUT(NOUT), .NIN(NIN)) pph_chk_inst (.*);

// ===== pph_host_bus.sv
// host side of the shared lines; released lines read back the inverse of their last value
`timescale 1ns/1ns
module pph_host_bus (input wire clock, host_oe, mux_bus_oe,
	input wire [7:0] host_data, mux_bus_out, output wire [7:0] mux_bus_in);
	reg [7:0] last = 8'h00;
	assign mux_bus_in = mux_bus_oe ? mux_bus_out :
		host_oe ? host_data : ~last;
	always @(posedge clock) last <= mux_bus_in;
endmodule // pph_host_bus

// ===== pph_host_port_tb_top.sv
// bench for the parallel host port
`timescale 1ns/1ns
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin failures++; \
	$display("Error %0t %h %h", $time, a, b); end end
module pph_host_port_tb_top;
	logic clock = 0, resetn = 0, mux_mode = 0, xfer_strobe = 0, host_oe = 1;
	logic addr_strobe = 0, data_strobe = 0, input_strobe = 0, mux_bus_oe;
	logic [7:0] port_addr = 0, write_data = 0, host_data = 0, read_data;
	logic [7:0] mux_bus_in, mux_bus_out, aux_control, dac_supply_one;
	logic [7:0] dac_supply_two, dac_supply_three;
	logic [63:0] in_ports = 64'hF7F6F5F4F3F2F1F0;
	logic [159:0] out_latches;
	logic [15:0] rows [0:3] = '{16'h00A5, 16'h0F5A, 16'h1081, 16'h1342};
	logic square_clock, pin_primary = 0;
	logic [1:0] pin_secondary = 0;
	wire [4:0] pin_out;
	int failures = 0, n_tests = 0;
	pph_host_port pph_host_port_inst (.*);
	pph_host_bus pph_host_bus_inst (.*);
	pph_pin_select pph_pin_select_inst (.primary(pin_primary),
		.secondary(pin_secondary), .zero_volt(pin_out[4]),
		.pullup_disable(pin_out[3]), .use_supply_one(pin_out[2]),
		.use_supply_two(pin_out[1]), .use_supply_three(pin_out[0]));
	task tick; @(posedge clock) #1; endtask
	task give_verdict;
		$display("%0d checks %0d errors", n_tests, failures);
		if (failures == 0 && n_tests > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	initial forever #5 clock = ~clock;
	initial begin
		#100000 failures++;
		give_verdict;
	end
	initial begin
		repeat (20) tick;
		resetn = 1;
		`CHK(out_latches, 160'h0)
		xfer_strobe = 1; // host times every write
		for (int i = 0; i < 4; i++) begin
			{port_addr, write_data} = rows[i];
			tick;
			`CHK(out_latches[8*port_addr+:8], write_data)
		end
		{port_addr, write_data} = 16'h14FF;
		tick;
		{xfer_strobe, port_addr} = 9'h01A;
		tick;
		`CHK({dac_supply_one, aux_control, read_data}, 24'h8142F2)
		$display("split done");
		{mux_mode, addr_strobe, host_data} = 10'h305;
		tick;
		{addr_strobe, data_strobe, host_data} = 10'h13C;
		tick;
		`CHK(out_latches[47:40], 8'h3C)
		{addr_strobe, data_strobe, host_data} = 10'h21B;
		tick;
		{addr_strobe, input_strobe, host_oe} = 3'b010;
		tick;
		`CHK({mux_bus_oe, mux_bus_out}, 9'h1F3)
		data_strobe = 1;
		tick;
		`CHK({mux_bus_oe, out_latches[47:40]}, 9'h03C)
		{input_strobe, data_strobe, addr_strobe, host_oe} = 4'h3;
		host_data = 8'h05;
		tick;
		{data_strobe, host_data} = 9'h199;
		tick;
		`CHK(out_latches[47:40], 8'h3C)
		{addr_strobe, host_data} = 9'h066;
		tick;
		`CHK(out_latches[47:40], 8'h66)
		$display("muxed done");
		for (int p = 0; p < 8; p++) begin
			{pin_primary, pin_secondary} = p[2:0];
			#1;
			`CHK(pin_out, p[2] ? (5'h08 >> p[1:0]) : 5'h10)
		end
		$display("pin decode done");
		{mux_mode, addr_strobe, data_strobe, input_strobe} = 4'h0;
		resetn = 0;
		tick;
		resetn = 1;
		`CHK({out_latches, square_clock}, 161'h0)
		repeat (15) tick;
		`CHK(square_clock, 1'b0)
		tick;
		`CHK(square_clock, 1'b1)
		$display("reset done");
		give_verdict;
	end
endmodule // pph_host_port_tb_top
